// file: rtl/crc16_byte.sv
// One-byte step of the LSB-first frame CRC
module crc16_byte #(
    parameter logic [15:0] POLY = frame_pkg::CRC_POLY_REFL
) (
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc_out
);
    logic [15:0] stage [0:8];

    // Data bits enter least significant first, as on the line
    assign stage[0] = crc_in ^ {8'h00, data};

    // One shift-and-reduce stage per bit
    for (genvar g = 0; g < 8; g++) begin : g_bit
        assign stage[g+1] = stage[g][0] ? ((stage[g] >> 1) ^ POLY) : (stage[g] >> 1);
    end

    assign crc_out = stage[8];
endmodule

// file: rtl/frame_pkg.sv
// Shared constants, states and carrier types for the frame field checker
package frame_pkg;

    // CRC: generator x^16+x^15+x^2+1 in LSB-first (reflected) form, register preset to all ones
    localparam logic [15:0] CRC_INIT      = 16'hFFFF;
    localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
    localparam logic [15:0] CRC_RESIDUE   = 16'h0000;

    // Initialization byte fields
    localparam int          INIT_TYPE_BIT = 7;
    localparam int          REQ_MSB       = 6;
    localparam int          REQ_LSB       = 4;
    localparam int          SIZE_MSB      = 2;
    localparam int          SIZE_LSB      = 0;
    localparam logic [2:0]  REQ_READ      = 3'h0;
    localparam logic [2:0]  REQ_WRITE     = 3'h1;

    // Target id byte fields
    localparam int          ID_MSB        = 5;
    localparam int          RESERVED_BIT_MSB      = 7;
    localparam int          RESERVED_BIT_LSB      = 6;

    // Frame layout in bytes
    localparam logic [3:0]  FRAME_FIXED   = 4'h7;  // init, id, two address bytes, one data byte, two CRC
    localparam logic [3:0]  DATA_FIRST    = 4'h4;  // index of first data byte in a command
    localparam logic [7:0]  HDR_BYTES     = 8'h04; // response bytes ahead of the data
    localparam logic [7:0]  CRC_LO_OFS    = 8'h05; // CRC low byte index is data length minus one plus this
    localparam int          MAX_WR_BYTES  = 8;
    localparam logic [3:0]  RX_CNT_RST    = 4'h0;
    localparam logic [7:0]  TX_IDX_RST    = 8'h00;
    localparam logic [2:0]  WR_IDX_RST    = 3'h0;

    typedef enum logic [2:0] {
        S_RX    = 3'b000,
        S_CHECK = 3'b001,
        S_WRITE = 3'b010,
        S_FETCH = 3'b011,
        S_SEND  = 3'b100
    } state_t;

    // Register file request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;

endpackage

// file: rtl/uart_frame_field_checker.sv
// Command frame checking and execution, and response frame generation
// How it works
// (RQ1) Target id is the six low bits of the id byte, 0x00 to 0x3F.
// (RQ2) Id byte bits 7 and 6 are reserved and sent as zero.
// (RQ3) Register address is two bytes, high byte first, in commands and responses.
// (RQ4) Register address names the single or first register of a block.
// (RQ5) Writes to an invalid address change nothing; the byte is dropped.
// (RQ6) Reads of an invalid address return 0x00 in that position.
// (RQ7) Mixed blocks: valid positions act normally, invalid ones get drop or zero.
// (RQ8) Read command data byte is response length minus one, 0x00 to 0x7F.
// (RQ9) Write data bytes go to successive registers from the start address.
// (RQ10) Response data holds register contents in address order from the start.
// (RQ11) CRC-16 with x^16+x^15+x^2+1, preset 0xFFFF, remainder appended.
// (RQ12) Receiver runs CRC over frame and CRC bytes; nonzero residue is an error.
// (RQ13) CRC is the first check once the whole frame has arrived.
// (RQ14) A bad CRC drops the frame: no access and no response.
// (RQ15) After a bad CRC only the CRC error is reported.
// (RQ16) Init byte bit 7 marks command; request type 000 read, 001 write.
// (RQ17) Answer only if target id equals the id for the selected direction.
// (RQ18) Every response carries the id byte right after the init byte.
// (RQ19) CRC runs in line order, each byte least significant bit first.
// (RQ20) Responses end with a CRC made the same way as the check.
module uart_frame_field_checker
    import frame_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                rx_valid,
    input  wire logic [7:0]          rx_data,
    input  wire logic                rx_clear,
    input  wire logic                dir_sel,
    input  wire logic [5:0]          id_for_direction_zero,
    input  wire logic [5:0]          id_for_direction_one,
    output frame_pkg::reg_req_t      reg_req,
    input  wire logic                reg_addr_ok,
    input  wire logic [7:0]          reg_rdata,
    output logic                     tx_valid,
    output logic [7:0]               tx_data,
    output logic                     tx_last,
    input  wire logic                tx_ready,
    output logic                     crc_err,
    output logic                     frame_err,
    output logic                     busy
);
    import frame_pkg::*;

    state_t      state_r;
    state_t      state_nxt;
    logic [3:0]  rx_cnt_r;
    logic [3:0]  frame_len_r;
    logic [7:0]  init_r;
    logic [7:0]  id_byte_r;
    logic [15:0] base_r;
    logic [7:0]  data_r [0:MAX_WR_BYTES-1];
    logic [15:0] crc_rx_r;
    logic [15:0] crc_rx_nxt;
    logic [15:0] crc_tx_r;
    logic [15:0] crc_tx_nxt;
    logic [7:0]  tx_idx_r;
    logic [7:0]  tx_data_r;
    logic [2:0]  wr_idx_r;
    logic [15:0] addr_r;
    logic [7:0]  wdata_r;
    logic        wr_try_r;
    logic        rd_try_r;
    logic        crc_err_r;
    logic        frame_err_r;
    logic [5:0]  my_id;
    logic        rx_take;
    logic        rx_done;
    logic        crc_good;
    logic        fields_ok;
    logic        is_read;
    logic        is_write;
    logic        id_match;
    logic [6:0]  rd_len_m1;
    logic [7:0]  crc_lo_idx;
    logic [7:0]  tx_idx_nxt;
    logic        tx_take;
    logic [3:0]  frame_len_now;

    crc16_byte u_crc_rx (
        .crc_in  (rx_cnt_r == RX_CNT_RST ? CRC_INIT : crc_rx_r),
        .data    (rx_data),
        .crc_out (crc_rx_nxt)
    );

    crc16_byte u_crc_tx (
        .crc_in  (crc_tx_r),
        .data    (tx_data_r),
        .crc_out (crc_tx_nxt)
    );

    // Frame decode of the buffered command
    assign my_id      = dir_sel ? id_for_direction_one : id_for_direction_zero;
    assign id_match   = id_byte_r[ID_MSB:0] == my_id;                                  // see RQ1, see RQ17
    assign is_read    = init_r[REQ_MSB:REQ_LSB] == REQ_READ;                           // see RQ16
    assign is_write   = init_r[REQ_MSB:REQ_LSB] == REQ_WRITE;
    assign fields_ok  = init_r[INIT_TYPE_BIT] && (is_read || is_write)
                        && id_byte_r[RESERVED_BIT_MSB:RESERVED_BIT_LSB] == 2'b00;                       // see RQ2, see RQ16
    assign crc_good   = crc_rx_r == CRC_RESIDUE;                                       // see RQ12
    assign rd_len_m1  = data_r[0][6:0];                                                // see RQ8
    assign crc_lo_idx = {1'b0, rd_len_m1} + CRC_LO_OFS;

    // Receive side: bytes are ignored while a frame is checked, executed or answered
    assign rx_take       = rx_valid && state_r == S_RX;
    assign frame_len_now = (rx_cnt_r == RX_CNT_RST) ? FRAME_FIXED + {1'b0, rx_data[SIZE_MSB:SIZE_LSB]} : frame_len_r;
    assign rx_done       = rx_take && (rx_cnt_r + 4'h1) == frame_len_now;

    // Transmit side
    assign tx_take    = state_r == S_SEND && tx_ready;
    assign tx_idx_nxt = tx_idx_r + 8'h01;

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_RX: begin
                if (rx_done) begin
                    state_nxt = S_CHECK;                                               // see RQ13
                end
            end
            S_CHECK: begin
                if (!crc_good || !fields_ok || !id_match) begin
                    state_nxt = S_RX;                                                  // see RQ14
                end else if (is_write) begin
                    state_nxt = S_WRITE;
                end else begin
                    state_nxt = S_SEND;
                end
            end
            S_WRITE: begin
                if (wr_idx_r == init_r[SIZE_MSB:SIZE_LSB]) begin
                    state_nxt = S_RX;
                end
            end
            S_FETCH: begin
                state_nxt = S_SEND;
            end
            S_SEND: begin
                if (tx_take) begin
                    if (tx_idx_r == crc_lo_idx + 8'h01) begin                          // CRC high byte ends it
                        state_nxt = S_RX;
                    end else if (tx_idx_nxt >= HDR_BYTES && tx_idx_nxt < crc_lo_idx) begin
                        state_nxt = S_FETCH;
                    end
                end
            end
            default: begin
                state_nxt = S_RX;
            end
        endcase
    end

    // State register; a line clear abandons any frame in flight
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= S_RX;
        end else if (rx_clear) begin
            state_r <= S_RX;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Capture of the command fields
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_cnt_r    <= RX_CNT_RST;
            frame_len_r <= FRAME_FIXED;
            init_r      <= 8'h00;
            id_byte_r   <= 8'h00;
            base_r      <= 16'h0000;
            for (int i = 0; i < MAX_WR_BYTES; i++) begin
                data_r[i] <= 8'h00;
            end
        end else if (rx_clear || rx_done) begin
            rx_cnt_r <= RX_CNT_RST;
        end else if (rx_take) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            case (rx_cnt_r)
                4'h0: begin
                    init_r      <= rx_data;
                    frame_len_r <= frame_len_now;
                end
                4'h1: id_byte_r <= rx_data;
                4'h2: base_r[15:8] <= rx_data;                                         // see RQ3
                4'h3: base_r[7:0] <= rx_data;
                default: begin
                    if (rx_cnt_r < frame_len_r - 4'h2) begin
                        data_r[3'(rx_cnt_r - DATA_FIRST)] <= rx_data;
                    end
                end
            endcase
        end
    end

    // Receive CRC runs over every byte, the two CRC bytes included
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            crc_rx_r <= CRC_INIT;
        end else if (rx_take) begin
            crc_rx_r <= crc_rx_nxt;                                                    // see RQ11, see RQ19
        end
    end

    // Error pulses: a bad CRC hides every other fault of the frame
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            crc_err_r   <= 1'b0;
            frame_err_r <= 1'b0;
        end else begin
            crc_err_r   <= state_r == S_CHECK && !crc_good;                            // see RQ12
            frame_err_r <= state_r == S_CHECK && crc_good && !fields_ok;               // see RQ15
        end
    end

    // Register requests for writes and read fetches
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_idx_r <= WR_IDX_RST;
            addr_r   <= 16'h0000;
            wdata_r  <= 8'h00;
            wr_try_r <= 1'b0;
            rd_try_r <= 1'b0;
        end else begin
            wr_try_r <= 1'b0;
            rd_try_r <= 1'b0;
            if (state_r == S_CHECK) begin
                wr_idx_r <= WR_IDX_RST;
            end else if (state_r == S_WRITE && !rx_clear) begin
                wr_idx_r <= wr_idx_r + 3'h1;
                addr_r   <= base_r + {13'h0000, wr_idx_r};                             // see RQ4, see RQ9
                wdata_r  <= data_r[wr_idx_r];
                wr_try_r <= 1'b1;
            end else if (tx_take && state_nxt == S_FETCH && !rx_clear) begin
                addr_r   <= base_r + {8'h00, tx_idx_nxt - HDR_BYTES};                  // see RQ10
                rd_try_r <= 1'b1;
            end
        end
    end

    // Strobes reach the register file only for valid addresses
    assign reg_req.wr    = wr_try_r && reg_addr_ok;                                    // see RQ5, see RQ7
    assign reg_req.rd    = rd_try_r && reg_addr_ok;
    assign reg_req.addr  = addr_r;
    assign reg_req.wdata = wdata_r;

    // Response byte stream and its CRC
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_idx_r  <= TX_IDX_RST;
            tx_data_r <= 8'h00;
            crc_tx_r  <= CRC_INIT;
        end else if (state_r == S_CHECK) begin
            tx_idx_r  <= TX_IDX_RST;
            tx_data_r <= {1'b0, rd_len_m1};
            crc_tx_r  <= CRC_INIT;
        end else if (state_r == S_FETCH) begin
            tx_data_r <= reg_addr_ok ? reg_rdata : 8'h00;                              // see RQ6, see RQ7
        end else if (tx_take) begin
            tx_idx_r <= tx_idx_nxt;
            if (tx_idx_r < crc_lo_idx) begin
                crc_tx_r <= crc_tx_nxt;                                                // see RQ20
            end
            if (tx_idx_nxt == 8'h01) begin
                tx_data_r <= {2'b00, my_id};                                           // see RQ18, see RQ2
            end else if (tx_idx_nxt == 8'h02) begin
                tx_data_r <= base_r[15:8];                                             // see RQ3
            end else if (tx_idx_nxt == 8'h03) begin
                tx_data_r <= base_r[7:0];
            end else if (tx_idx_nxt == crc_lo_idx) begin
                tx_data_r <= crc_tx_nxt[7:0];                                          // see RQ20
            end else if (tx_idx_nxt == crc_lo_idx + 8'h01) begin
                tx_data_r <= crc_tx_r[15:8];
            end
        end
    end

    assign tx_valid  = state_r == S_SEND;
    assign tx_data   = tx_data_r;
    assign tx_last   = state_r == S_SEND && tx_idx_r == crc_lo_idx + 8'h01;
    assign crc_err   = crc_err_r;
    assign frame_err = frame_err_r;
    assign busy      = state_r != S_RX;
endmodule

// file: sim/host_model.sv
// Host side: sends command frames and collects response bytes
module host_model (
    input  wire logic       clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got[$];
    bit         slow = 1'b0;
    int         last_n = 0;
    // Frame CRC, each byte least significant bit first
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i])
            for (int b = 0; b < 8; b++)
                c = (c[0] ^ q[i][b]) ? (c >> 1) ^ 16'hA001 : c >> 1;
        return c;
    endfunction
    // Sends a frame with its CRC low byte first; bad spoils the CRC
    task automatic send(input logic [7:0] q[$], input bit bad);
        logic [15:0] c;
        c = crc16(q) ^ {15'h0, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            @(posedge clk);
            #1 rx_valid = 1'b1;
            rx_data = q[i];
        end
        @(posedge clk);
        #1 rx_valid = 1'b0;
        rx_data = ~rx_data; // Released line shows no stale byte
    endtask
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    // Takes response bytes, stalling every other cycle when slow
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready) begin
            got.push_back(tx_data);
            if (tx_last === 1'b1)
                last_n = got.size(); // Bytes taken up to the marked last one
        end
        tx_ready <= #1 slow ? ~tx_ready : 1'b1;
    end
endmodule

// file: sim/uart_frame_field_checker_asserts.sv
// Port checks for the frame field checker
module uart_frame_field_checker_asserts
    import frame_pkg::*;
(
    input wire logic                clk,
    input wire logic                resetn,
    input wire logic                dir_sel,
    input wire logic [5:0]          id_for_direction_zero,
    input wire logic [5:0]          id_for_direction_one,
    input wire frame_pkg::reg_req_t reg_req,
    input wire logic                reg_addr_ok,
    input wire logic                tx_valid,
    input wire logic [7:0]          tx_data,
    input wire logic                tx_last,
    input wire logic                tx_ready,
    input wire logic                crc_err,
    input wire logic                frame_err,
    input wire logic                busy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [7:0] idx_r;
    logic [7:0] len_r;
    // Counts response bytes taken and keeps the announced length
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idx_r <= 8'h00;
            len_r <= 8'h00;
        end else if (!busy || (tx_valid && tx_ready && tx_last)) begin
            idx_r <= 8'h00;
        end else if (tx_valid && tx_ready) begin
            idx_r <= idx_r + 8'h01;
            if (idx_r == 8'h00)
                len_r <= {1'b0, tx_data[6:0]};
        end
    end
    sequence s_take;
        tx_valid && tx_ready;
    endsequence
    sequence s_fetch;
        !tx_valid ##1 tx_valid;
    endsequence
    chk_err_alone: assert property (!(crc_err && frame_err))
        else $error("crc and frame error together");
    chk_crc_drop: assert property (crc_err |-> !tx_valid && !busy ##1 !reg_req.wr && !tx_valid)
        else $error("activity after a crc error");
    chk_wr_valid: assert property (reg_req.wr |-> reg_addr_ok && !tx_valid && !reg_req.rd)
        else $error("write issued to an invalid address");
    chk_rd_fetch: assert property (reg_req.rd |-> reg_addr_ok ##0 s_fetch)
        else $error("read fetch misplaced");
    chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("response byte changed while stalled");
    chk_resp_type: assert property (tx_valid && idx_r == 8'h00 |-> !tx_data[7])
        else $error("response init byte marks a command");
    chk_id_byte: assert property (tx_valid && idx_r == 8'h01 |->
        tx_data == {2'b00, dir_sel ? id_for_direction_one : id_for_direction_zero})
        else $error("response id byte wrong");
    chk_resp_len: assert property (tx_valid && tx_last |-> idx_r == len_r + 8'h06)
        else $error("response length wrong");
    chk_last_idle: assert property (s_take ##0 tx_last |=> !busy && !tx_valid)
        else $error("still busy after the last byte");
endmodule
bind uart_frame_field_checker uart_frame_field_checker_asserts u_chk (.clk, .resetn, .dir_sel,
    .id_for_direction_zero, .id_for_direction_one, .reg_req, .reg_addr_ok, .tx_valid, .tx_data,
    .tx_last, .tx_ready, .crc_err, .frame_err, .busy);

// file: sim/uart_frame_field_checker_tb.sv
// Self-checking bench for the frame field checker
module uart_frame_field_checker_tb
    import frame_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, resetn, rx_valid, rx_clear, dir_sel, reg_addr_ok, tx_ready, tx_valid, tx_last;
    logic       crc_err, frame_err, busy;
    logic [7:0] rx_data, reg_rdata, tx_data;
    logic [5:0] id0, id1;
    reg_req_t   reg_req;
    logic [7:0] mem [256];
    int         mismatches = 0, num_checks = 0, n_crc = 0, n_frm = 0;
    uart_frame_field_checker u_dut (.clk, .resetn, .rx_valid, .rx_data, .rx_clear, .dir_sel,
        .id_for_direction_zero(id0), .id_for_direction_one(id1), .reg_req, .reg_addr_ok,
        .reg_rdata, .tx_valid, .tx_data, .tx_last, .tx_ready, .crc_err, .frame_err, .busy);
    host_model u_host (.clk, .tx_valid, .tx_data, .tx_last, .rx_valid, .rx_data, .tx_ready);
    // Register file with holes where address bit 2 or the high byte is set
    function automatic logic ok(input logic [15:0] a);
        return a[15:8] == 8'h00 && !a[2];
    endfunction
    function automatic logic [5:0] own();
        return dir_sel ? id1 : id0;
    endfunction
    assign reg_addr_ok = ok(reg_req.addr);
    assign reg_rdata = reg_addr_ok ? mem[reg_req.addr[7:0]] : 8'hEE; // Junk for holes
    // Stores writes and counts error pulses
    always @(posedge clk) begin
        if (reg_req.wr === 1'b1)
            mem[reg_req.addr[7:0]] <= reg_req.wdata;
        n_crc <= n_crc + int'(crc_err === 1'b1);
        n_frm <= n_frm + int'(frame_err === 1'b1);
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Waits for the block to go idle, bounded
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        #1;
        if (n >= 1000) begin
            mismatches++;
            end_of_test();
        end
    endtask
    // Reads lm1+1 bytes from base and compares the whole response
    task automatic do_read(input logic [5:0] id, input logic [15:0] base, input logic [6:0] lm1);
        logic [7:0]  f[$];
        logic [7:0]  e[$];
        logic [15:0] c;
        int          cf;
        f = '{8'h80, {2'b00, id}, base[15:8], base[7:0], {1'b0, lm1}};
        cf = n_frm;
        u_host.got.delete();
        u_host.last_n = 0;
        u_host.send(f, 1'b0);
        wait_idle();
        if (id == own()) begin
            e = '{{1'b0, lm1}, {2'b00, own()}, base[15:8], base[7:0]};
            for (int i = 0; i <= int'(lm1); i++)
                e.push_back(ok(base + 16'(i)) ? mem[base[7:0] + 8'(i)] : 8'h00);
            c = u_host.crc16(e);
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
        end
        check("resp_len", 16'(u_host.got.size()), 16'(e.size()));
        check("tx_last", 16'(u_host.last_n), 16'(e.size()));
        foreach (e[i]) check("resp_byte", {8'h00, u_host.got[i]}, {8'h00, e[i]});
        check("frame_err", 16'(n_frm - cf), 16'h0000);
    endtask
    // Writes nm1+1 bytes from base and compares every register
    task automatic do_write(input logic [5:0] id, input logic [15:0] base, input logic [2:0] nm1, input bit bad);
        logic [7:0] f[$];
        logic [7:0] em [256];
        em = mem;
        f = '{{5'b10010, nm1}, {2'b00, id}, base[15:8], base[7:0]};
        for (int i = 0; i <= int'(nm1); i++) begin
            f.push_back(8'hA0 ^ 8'(i * 9));
            if (!bad && id == own() && ok(base + 16'(i)))
                em[base[7:0] + 8'(i)] = 8'hA0 ^ 8'(i * 9);
        end
        u_host.send(f, bad);
        wait_idle();
        foreach (em[i]) check("reg", {8'h00, mem[i]}, {8'h00, em[i]});
    endtask
    // Sends a faulty frame and checks which error is flagged
    task automatic do_bad(input logic [7:0] init, input logic [7:0] idb, input bit bad);
        logic [7:0] f[$];
        int         cc, cf;
        f = '{init, idb, 8'h00, 8'h10, 8'h00};
        cc = n_crc;
        cf = n_frm;
        u_host.got.delete();
        u_host.send(f, bad);
        wait_idle();
        check("crc_err", 16'(n_crc - cc), {15'h0, bad});
        check("frame_err", 16'(n_frm - cf), {15'h0, !bad});
        check("no_resp", 16'(u_host.got.size()), 16'h0000);
    endtask
    // Full span read with holes under stalls, then a single hole read
    task automatic t_read;
        u_host.slow = 1'b1;
        do_read(id0, 16'h0000, 7'h7F);
        u_host.slow = 1'b0;
        do_read(id0, 16'h0104, 7'h00);
        $display("t_read done");
    endtask
    // Eight byte write over a hole, read back, then a write with bad CRC
    task automatic t_write;
        do_write(id0, 16'h0002, 3'h7, 1'b0);
        do_read(id0, 16'h0000, 7'h0B);
        do_write(id0, 16'h0008, 3'h3, 1'b1);
        $display("t_write done");
    endtask
    // Response type, reserved request and reserved id bits, good and bad CRC
    task automatic t_errors;
        logic [7:0] ini [3];
        logic [7:0] idb [3];
        ini = '{8'h00, 8'hA0, 8'h80};
        idb = '{{2'b00, id0}, {2'b00, id0}, {2'b01, id0}};
        for (int k = 0; k < 6; k++)
            do_bad(ini[k % 3], idb[k % 3], k >= 3);
        $display("t_errors done");
    endtask
    // Second direction id answers, the first is ignored
    task automatic t_dir;
        dir_sel = 1'b1;
        do_read(id1, 16'h0010, 7'h02);
        do_read(id0, 16'h0010, 7'h02);
        do_write(id0, 16'h0010, 3'h1, 1'b0);
        dir_sel = 1'b0;
        $display("t_dir done");
    endtask
    // Line clear cuts a read short, the tail is junk, and a second clear realigns the receiver
    task automatic t_clear;
        logic [7:0] f[$];
        int         ce;
        f = '{8'h80, {2'b00, id0}, 8'h00, 8'h20, 8'h01};
        ce = n_crc + n_frm;
        u_host.got.delete();
        fork
            u_host.send(f, 1'b0);
            begin
                repeat (4) @(posedge clk);
                #1 rx_clear = 1'b1;
                @(posedge clk);
                #1 rx_clear = 1'b0;
            end
        join
        repeat (2) @(posedge clk);
        #1 rx_clear = 1'b1;
        @(posedge clk);
        #1 rx_clear = 1'b0;
        wait_idle();
        check("cut_resp", 16'(u_host.got.size()), 16'h0000);
        check("cut_err", 16'(n_crc + n_frm - ce), 16'h0000);
        do_read(id0, 16'h0020, 7'h01);
        $display("t_clear done");
    endtask
    initial begin
        resetn = 1'b0;
        rx_clear = 1'b0;
        dir_sel = 1'b0;
        id0 = 6'h3F;
        id1 = 6'h15;
        foreach (mem[i]) mem[i] = 8'(i * 7 + 3);
        repeat (8) @(posedge clk);
        #1 resetn = 1'b1;
        t_read();
        t_write();
        t_errors();
        t_dir();
        t_clear();
        end_of_test();
    end
endmodule
